// [fers_pkg.sv]
// constants, types and opcodes for the extended read status register bank
package fers_pkg;

  // register layout and reset value
  localparam logic [7:0] FERS_EXT_RESET = 8'hf0;
  localparam int FERS_BUSY_BIT = 0;
  localparam int FERS_PROT_BIT = 1;
  localparam int FERS_PERR_BIT = 2;
  localparam int FERS_EERR_BIT = 3;
  localparam int FERS_RSVD_BIT = 4;
  localparam int FERS_DS_LSB = 5;
  localparam int FERS_DS_MSB = 7;
  localparam logic [7:0] FERS_WR_MASK = 8'he0;
  localparam logic [7:0] FERS_RSVD_VAL = 8'h10;

  // register write opcodes
  localparam logic [7:0] FERS_OP_SET_EXT_NV = 8'h85;
  localparam logic [7:0] FERS_OP_SET_EXT_V = 8'h83;

  // read opcodes that carry dummy cycles
  localparam logic [7:0] FERS_OP_FAST_RD = 8'h0b;
  localparam logic [7:0] FERS_OP_FAST_RD_DTR = 8'h0d;
  localparam logic [7:0] FERS_OP_DUAL_OUT = 8'h3b;
  localparam logic [7:0] FERS_OP_DUAL_IO = 8'hbb;
  localparam logic [7:0] FERS_OP_DUAL_IO_DTR = 8'hbd;
  localparam logic [7:0] FERS_OP_QUAD_OUT = 8'h6b;
  localparam logic [7:0] FERS_OP_QUAD_IO = 8'heb;
  localparam logic [7:0] FERS_OP_QUAD_IO_DTR = 8'hed;

  // default dummy counts when the configured count is zero
  localparam logic [3:0] FERS_DUMMY_SPI = 4'h8;
  localparam logic [3:0] FERS_DUMMY_QUAD = 4'h6;
  localparam logic [3:0] FERS_DUMMY_DUAL = 4'h4;

  // drive strength codes
  localparam logic [2:0] FERS_DS_RSVD_A = 3'h0;
  localparam logic [2:0] FERS_DS_RSVD_B = 3'h4;

  // kind of internal operation that reports its outcome
  typedef enum logic [3:0] {
    FERS_K_PAGE_PROG = 4'b0000,
    FERS_K_QUAD_PROG = 4'b0001,
    FERS_K_FUNC_WRITE = 4'b0010,
    FERS_K_INFO_PROG = 4'b0011,
    FERS_K_SECT_ERASE = 4'b0100,
    FERS_K_BLK32_ERASE = 4'b0101,
    FERS_K_BLK64_ERASE = 4'b0110,
    FERS_K_CHIP_ERASE = 4'b0111,
    FERS_K_INFO_ERASE = 4'b1000,
    FERS_K_STATUS_WRITE = 4'b1001,
    FERS_K_NVREG_WRITE = 4'b1010
  } fers_kind_t;

  // decoded command handed over at the end of a frame
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] data;
    logic qpi_mode;
  } fers_cmd_t;

  // outcome of a finished program, erase or register update
  typedef struct packed {
    fers_kind_t kind;
    logic erase_fail;
    logic program_fail;
    logic protected_hit;
    logic suspended_hit;
    logic info_row_locked;
    logic status_locked;
    logic [3:0] block_protect_bits;
  } fers_result_t;

  // sticky error flags in register order
  typedef struct packed {
    logic erase_err;
    logic program_err;
    logic protect_violation_flag;
  } fers_err_t;

endpackage

// [fers_regs.sv]
// extended read status register bank with error flags and dummy cycle selection
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - zero dummy setting gives 8 spi/dual/quad-out, 6 qpi/quad-io, 4 dual-io cycles.
// - dual io double rate read is refused in qpi instruction mode.
// - drive strength field bits 7..5 selects output strength, two codes reserved.
// - low four status bits are unaffected by set extended parameter commands.
// - 85h writes the non-volatile copy, 83h the volatile copy.
// - bit 0 mirrors the write in progress busy indicator.
// - bit 4 reads one always, writes ignored.
// - protection flag sets on protected program/erase or locked info row access.
// - page, quad page, function writes set program flag; protected page/quad page adds protection flag.
// - info row program sets program flag; locked region sets program and protection.
// - non-volatile update erase failure sets erase flag, program failure program flag.
// - locked status register write sets protection and erase flags.
// - erases set erase flag on failure; protected targets add protection flag.
// - chip erase with block protect bits nonzero sets erase and protection flags.
// - one-time bits only go to one; clearing attempts raise no flag.
// - read-only bits of written data are dropped without any flag.
// - error flags stay set until clear command, hardware or software reset.
// - commands keep executing while error flags are set.
// - register writes need the write enable latch, otherwise ignored.
// - configured dummy field 1..15 overrides, zero selects defaults.
module fers_regs #(
  parameter logic [7:0] CLR_OPCODE = 8'h82,
  parameter int DUMMY_W = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic soft_reset_i,
  input wire logic cmd_valid_i,
  input wire fers_pkg::fers_cmd_t cmd_i,
  input wire logic write_enable_latch_i,
  input wire logic write_in_progress_i,
  input wire logic [DUMMY_W-1:0] dummy_cfg_i,
  input wire logic result_valid_i,
  input wire fers_pkg::fers_result_t result_i,
  output logic [7:0] ext_reg_o,
  output logic [7:0] ext_reg_nv_o,
  output logic [2:0] drive_strength_o,
  output logic drive_strength_rsvd_o,
  output logic nv_write_req_o,
  output logic [7:0] nv_write_data_o,
  output logic dummy_valid_o,
  output logic [DUMMY_W-1:0] dummy_cycles_o,
  output logic cmd_rejected_o
);
  import fers_pkg::*;

  // the dummy field is four bits wide; narrower cannot hold 15
  if (DUMMY_W != 4)
  begin : g_bad_width
    $error("fers_regs: DUMMY_W must be 4");
  end

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  // flags raised by one finished operation
  function automatic fers_err_t fers_err_from(input fers_result_t r);
    fers_err_t e;
    e = '0;
    case (r.kind)
      FERS_K_PAGE_PROG, FERS_K_QUAD_PROG:
      begin
        e.program_err = r.program_fail | r.protected_hit | r.suspended_hit;
        e.protect_violation_flag = r.protected_hit | r.suspended_hit;
      end
      // function write; one-time zero writes report nothing
      FERS_K_FUNC_WRITE:
      begin
        e.program_err = r.program_fail;
      end
      FERS_K_INFO_PROG:
      begin
        e.program_err = r.program_fail | r.info_row_locked;
        e.protect_violation_flag = r.info_row_locked;
      end
      FERS_K_SECT_ERASE, FERS_K_BLK32_ERASE, FERS_K_BLK64_ERASE:
      begin
        e.erase_err = r.erase_fail | r.protected_hit;
        e.protect_violation_flag = r.protected_hit;
      end
      // chip erase with any block protected
      FERS_K_CHIP_ERASE:
      begin
        e.erase_err = r.erase_fail | r.protected_hit | (|r.block_protect_bits);
        e.protect_violation_flag = r.protected_hit | (|r.block_protect_bits);
      end
      FERS_K_INFO_ERASE:
      begin
        e.erase_err = r.erase_fail | r.info_row_locked;
        e.protect_violation_flag = r.info_row_locked;
      end
      FERS_K_STATUS_WRITE:
      begin
        e.erase_err = r.erase_fail | r.status_locked;
        e.program_err = r.program_fail;
        e.protect_violation_flag = r.status_locked;
      end
      // erase then program of non-volatile bits
      FERS_K_NVREG_WRITE:
      begin
        e.erase_err = r.erase_fail;
        e.program_err = r.program_fail;
      end
      default:
      begin
        e = '0;
      end
    endcase
    return e;
  endfunction

  // dummy count for a read opcode; zero means not a dummy read
  function automatic logic [3:0] fers_dummy(input logic [7:0] op, input logic qpi,
                                            input logic [3:0] cfg);
    logic [3:0] d;
    d = 4'h0;
    case (op)
      // single wire fast read 8, qpi 6
      FERS_OP_FAST_RD, FERS_OP_FAST_RD_DTR:
        d = qpi ? FERS_DUMMY_QUAD : FERS_DUMMY_SPI;
      FERS_OP_DUAL_OUT, FERS_OP_QUAD_OUT:
        d = FERS_DUMMY_SPI;
      FERS_OP_DUAL_IO, FERS_OP_DUAL_IO_DTR:
        d = FERS_DUMMY_DUAL;
      FERS_OP_QUAD_IO, FERS_OP_QUAD_IO_DTR:
        d = FERS_DUMMY_QUAD;
      default:
        d = 4'h0;
    endcase
    if (d != 4'h0 && cfg != 4'h0)
    begin
      d = cfg;
    end
    return d;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // command decode

  logic is_set_nv;
  logic is_set_v;
  logic is_clear;
  logic is_dual_dtr_qpi;
  logic [3:0] dummy_lookup;
  fers_err_t err_set;

  // register writes only with the latch set
  assign is_set_nv = cmd_valid_i && cmd_i.opcode == FERS_OP_SET_EXT_NV && write_enable_latch_i;
  assign is_set_v = cmd_valid_i && cmd_i.opcode == FERS_OP_SET_EXT_V && write_enable_latch_i;
  // clearing is a plain command, never blocked by set flags
  assign is_clear = cmd_valid_i && cmd_i.opcode == CLR_OPCODE;
  // double rate dual io is single wire only
  assign is_dual_dtr_qpi = cmd_valid_i && cmd_i.qpi_mode && cmd_i.opcode == FERS_OP_DUAL_IO_DTR;
  assign dummy_lookup = fers_dummy(cmd_i.opcode, cmd_i.qpi_mode, dummy_cfg_i);
  assign err_set = result_valid_i ? fers_err_from(result_i) : '0;

  //////////////////////////////////////////////////////////////////////////////
  // drive strength copies

  logic [2:0] ds_v_r;
  logic [2:0] ds_v_nxt;
  logic [2:0] ds_nv_r;

  // volatile copy: 83h, 85h also updates it; soft reset reloads non-volatile
  always_comb
  begin
    ds_v_nxt = ds_v_r;
    if (soft_reset_i)
    begin
      ds_v_nxt = ds_nv_r;
    end
    // both set commands write the drive field
    // only bits 7..5 are taken, flag bits untouched
    else if (is_set_v || is_set_nv)
    begin
      ds_v_nxt = cmd_i.data[FERS_DS_MSB:FERS_DS_LSB];
    end
  end

  // hardware reset gives the default; the nv copy itself survives soft reset
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ds_v_r <= FERS_EXT_RESET[FERS_DS_MSB:FERS_DS_LSB];
    end
    else
    begin
      ds_v_r <= ds_v_nxt;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ds_nv_r <= FERS_EXT_RESET[FERS_DS_MSB:FERS_DS_LSB];
    end
    else if (is_set_nv)
    begin
      ds_nv_r <= cmd_i.data[FERS_DS_MSB:FERS_DS_LSB];
    end
  end

  // request to the array engine for the erase/program update of the nv bits
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      nv_write_req_o <= 1'b0;
      nv_write_data_o <= FERS_EXT_RESET;
    end
    else
    begin
      nv_write_req_o <= is_set_nv;
      if (is_set_nv)
      begin
        // read-only bits of the data byte are dropped
        nv_write_data_o <= (cmd_i.data & FERS_WR_MASK) | FERS_RSVD_VAL;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // sticky error flags

  fers_err_t err_r;
  fers_err_t err_nxt;

  // set wins over clear so a failure landing on a clear is kept
  always_comb
  begin
    err_nxt = err_r;
    // besides hardware reset, only clear command or soft reset drop the flags
    if (is_clear || soft_reset_i)
    begin
      err_nxt = '0;
    end
    // set from the outcome of each operation
    err_nxt = err_nxt | err_set;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      err_r <= '0;
    end
    else
    begin
      err_r <= err_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // busy mirror

  logic busy_r;

  // one cycle behind the status busy bit
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      busy_r <= 1'b0;
    end
    else
    begin
      busy_r <= write_in_progress_i;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read-back and strength outputs

  // assembled from flops only, so the read value is glitch free
  always_comb
  begin
    ext_reg_o = '0;
    ext_reg_o[FERS_DS_MSB:FERS_DS_LSB] = ds_v_r;
    ext_reg_o[FERS_RSVD_BIT] = 1'b1;
    ext_reg_o[FERS_EERR_BIT] = err_r.erase_err;
    ext_reg_o[FERS_PERR_BIT] = err_r.program_err;
    ext_reg_o[FERS_PROT_BIT] = err_r.protect_violation_flag;
    ext_reg_o[FERS_BUSY_BIT] = busy_r;
  end

  // nv image keeps the flag bits at their defaults
  assign ext_reg_nv_o = {ds_nv_r, FERS_RSVD_VAL[4:0]};

  // drive code goes to the pad driver; reserved codes flagged
  assign drive_strength_o = ds_v_r;
  assign drive_strength_rsvd_o = ds_v_r == FERS_DS_RSVD_A || ds_v_r == FERS_DS_RSVD_B;

  //////////////////////////////////////////////////////////////////////////////
  // read dummy selection

  // registered one cycle after the command is handed over
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      dummy_valid_o <= 1'b0;
      dummy_cycles_o <= '0;
      cmd_rejected_o <= 1'b0;
    end
    else
    begin
      // refused command gets no dummy count
      cmd_rejected_o <= is_dual_dtr_qpi;
      dummy_valid_o <= cmd_valid_i && !is_dual_dtr_qpi && dummy_lookup != 4'h0;
      if (cmd_valid_i && !is_dual_dtr_qpi && dummy_lookup != 4'h0)
      begin
        dummy_cycles_o <= dummy_lookup;
      end
    end
  end

endmodule
`default_nettype wire

// [fers_regs_assertions.sv]
// concurrent checks on the extended read status register ports
`timescale 1ns/1ps
`default_nettype none
module fers_regs_chk #(
  parameter logic [7:0] CLR_OPCODE = 8'h82,
  parameter int DUMMY_W = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic soft_reset_i,
  input wire logic cmd_valid_i,
  input wire fers_pkg::fers_cmd_t cmd_i,
  input wire logic write_enable_latch_i,
  input wire logic write_in_progress_i,
  input wire logic [DUMMY_W-1:0] dummy_cfg_i,
  input wire logic result_valid_i,
  input wire fers_pkg::fers_result_t result_i,
  input wire logic [7:0] ext_reg_o,
  input wire logic [7:0] ext_reg_nv_o,
  input wire logic nv_write_req_o,
  input wire logic [7:0] nv_write_data_o,
  input wire logic dummy_valid_o,
  input wire logic [DUMMY_W-1:0] dummy_cycles_o,
  input wire logic cmd_rejected_o
);
  import fers_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // accepted register write, soft reset excluded since it reloads the drive
  sequence wr_cmd(op);
    cmd_valid_i && cmd_i.opcode == op && write_enable_latch_i && !soft_reset_i;
  endsequence
  sequence clr_req;
    cmd_valid_i && cmd_i.opcode == CLR_OPCODE && !result_valid_i && !soft_reset_i;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  a_vol_drive:
    assert property (wr_cmd(8'h83) |=> ext_reg_o[7:5] == $past(cmd_i.data[7:5]))
    else $error("volatile drive not written");
  a_nv_write:
    assert property (wr_cmd(8'h85) |=> nv_write_req_o && ext_reg_nv_o == nv_write_data_o
      && nv_write_data_o == (($past(cmd_i.data) & 8'he0) | 8'h10))
    else $error("nv write wrong");
  a_low_keep:
    assert property (wr_cmd(8'h83) ##0 !result_valid_i |=> $stable(ext_reg_o[3:1]))
    else $error("status bits moved on write");
  a_wel_gate:
    assert property (cmd_valid_i && !write_enable_latch_i && !soft_reset_i
      |=> !nv_write_req_o && $stable(ext_reg_o[7:5]))
    else $error("write taken without latch");
  a_bd_refuse:
    assert property (cmd_valid_i && cmd_i.opcode == 8'hbd && cmd_i.qpi_mode
      |=> cmd_rejected_o && !dummy_valid_o)
    else $error("qpi dual io dtr taken");
  a_dual_io_dflt:
    assert property (cmd_valid_i && cmd_i.opcode == 8'hbb && dummy_cfg_i == 0
      |=> dummy_valid_o && dummy_cycles_o == 4)
    else $error("dual io default dummy wrong");
  a_busy_mirror:
    assert property (!$past(rst_i) |-> ext_reg_o[0] == $past(write_in_progress_i))
    else $error("busy bit not mirrored");
  a_rsvd_one:
    assert property (ext_reg_o[4] && ext_reg_nv_o[4:0] == 5'h10)
    else $error("reserved bit not one");
  a_flag_sticky:
    assert property (!(cmd_valid_i && cmd_i.opcode == CLR_OPCODE) && !soft_reset_i
      |=> (ext_reg_o[3:1] & $past(ext_reg_o[3:1])) == $past(ext_reg_o[3:1]))
    else $error("flag dropped");
  a_chip_prot:
    assert property (result_valid_i && result_i.kind == FERS_K_CHIP_ERASE
      && result_i.block_protect_bits != 4'h0 |=> ext_reg_o[3] && ext_reg_o[1])
    else $error("chip erase protect flags");
  a_clear_flags:
    assert property (clr_req |=> ext_reg_o[3:1] == 3'h0 && $stable(ext_reg_o[7:5]))
    else $error("clear wrong");
  a_prog_fail:
    assert property (result_valid_i && result_i.kind == FERS_K_PAGE_PROG
      && result_i.program_fail |=> ext_reg_o[2])
    else $error("program failure not flagged");
endmodule
`default_nettype wire

// [fers_host.sv]
// host controller model issuing decoded commands to the register bank
`timescale 1ns/1ps
`default_nettype none
module fers_host (
  input wire logic clk_i,
  output fers_pkg::fers_cmd_t cmd_o,
  output logic cmd_valid_o,
  output logic wel_o,
  output logic [3:0] dummy_o
);
  import fers_pkg::*;
  // idle values before the first frame
  initial
  begin
    cmd_o = '0;
    cmd_valid_o = 1'b0;
    wel_o = 1'b0;
    dummy_o = 4'h0;
  end
  task automatic send(input logic [7:0] op, input logic [7:0] d, input logic q,
                      input logic w, input logic [3:0] dc);
    @(posedge clk_i);
    cmd_o <= '{opcode: op, data: d, qpi_mode: q};
    cmd_valid_o <= 1'b1;
    wel_o <= w;
    dummy_o <= dc;
    @(posedge clk_i);
    cmd_valid_o <= 1'b0;
    cmd_o <= ~cmd_o;
    #1;
  endtask
endmodule
`default_nettype wire

// [flash_ext_read_status_regs_tb.sv]
// self-checking bench for the extended read status register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin bad_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module flash_ext_read_status_regs_tb;
  import fers_pkg::*;
  localparam logic [7:0] clr_op = 8'h82;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic soft_reset_i = 1'b0;
  logic write_in_progress = 1'b0;
  logic result_valid_i = 1'b0;
  fers_result_t result_i = '0;
  fers_cmd_t cmd;
  logic cmd_valid, write_enable_latch, ds_rsvd, nv_req, dum_v, rej;
  logic [3:0] dcfg, dum_n;
  logic [7:0] ext_reg, ext_nv, nv_data;
  logic [2:0] ds;
  int bad_count = 0;
  int comparisons = 0;
  int cyc = 0;
  logic [31:0] seed = 32'd98;
  logic [7:0] rd_ops [8] = '{FERS_OP_FAST_RD, FERS_OP_FAST_RD_DTR, FERS_OP_QUAD_IO,
    FERS_OP_QUAD_IO_DTR, FERS_OP_DUAL_OUT, FERS_OP_QUAD_OUT, FERS_OP_DUAL_IO, FERS_OP_DUAL_IO_DTR};
  fers_host u_host (.clk_i(clk_i), .cmd_o(cmd), .cmd_valid_o(cmd_valid), .wel_o(write_enable_latch),
    .dummy_o(dcfg));
  fers_regs #(.CLR_OPCODE(clr_op), .DUMMY_W(4)) dut (.clk_i(clk_i), .rst_i(rst_i),
    .soft_reset_i(soft_reset_i), .cmd_valid_i(cmd_valid), .cmd_i(cmd),
    .write_enable_latch_i(write_enable_latch), .write_in_progress_i(write_in_progress), .dummy_cfg_i(dcfg),
    .result_valid_i(result_valid_i), .result_i(result_i), .ext_reg_o(ext_reg),
    .ext_reg_nv_o(ext_nv), .drive_strength_o(ds), .drive_strength_rsvd_o(ds_rsvd),
    .nv_write_req_o(nv_req), .nv_write_data_o(nv_data), .dummy_valid_o(dum_v),
    .dummy_cycles_o(dum_n), .cmd_rejected_o(rej));
  always #2 clk_i = ~clk_i;
  // busy toggles on its own; the cycle ceiling cuts a hang short
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    write_in_progress <= cyc[2];
    if (cyc == 3000)
    begin
      bad_count++;
      finish_test();
    end
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [3:0] exp_dum(logic [7:0] op, logic q, logic [3:0] c);
    if (c != 4'h0) return c;
    case (op)
      FERS_OP_FAST_RD, FERS_OP_FAST_RD_DTR: return q ? 4'h6 : 4'h8;
      FERS_OP_DUAL_IO, FERS_OP_DUAL_IO_DTR: return 4'h4;
      FERS_OP_QUAD_IO, FERS_OP_QUAD_IO_DTR: return 4'h6;
      default: return 4'h8;
    endcase
  endfunction
  // outcome of kind k with fault f and protection hit p; returns flags {erase,program,protect}
  function automatic logic [2:0] mk(int k, logic f, logic p, output fers_result_t r);
    r = '0;
    r.kind = fers_kind_t'(k);
    r.erase_fail = (k >= 4) & f;
    r.program_fail = (k < 4) ? f : (k == 10) & p;
    r.protected_hit = (k == 0 || (k > 3 && k < 7)) & p;
    // quad program lands in an erase-suspended sector instead
    r.suspended_hit = (k == 1) & p;
    r.info_row_locked = (k == 3 || k == 8) & p;
    r.status_locked = (k == 9) & p;
    r.block_protect_bits = (k == 7 && p) ? 4'h8 : 4'h0;
    if (k < 4) return {1'b0, f | (p & (k != 2)), p & (k != 2)};
    if (k == 10) return {f, p, 1'b0};
    return {f | p, 1'b0, p};
  endfunction
  task automatic put_result(input fers_result_t r);
    @(posedge clk_i);
    result_i <= r;
    result_valid_i <= 1'b1;
    @(posedge clk_i);
    result_valid_i <= 1'b0;
    #1;
  endtask
  task automatic finish_test();
    if (bad_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // main sequence: reset, drive codes, nv copy, latch, dummy counts, flags
  initial
  begin
    logic [7:0] d;
    logic [31:0] rn;
    logic [2:0] fl;
    logic [3:0] dc;
    logic q;
    fers_result_t r;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    `CHK({ext_reg, ext_nv}, {FERS_EXT_RESET, 8'hf0})
    for (int c = 0; c < 8; c++)
    begin
      d = 8'(xs());
      d[7:5] = c[2:0];
      u_host.send(FERS_OP_SET_EXT_V, d, 1'b0, 1'b1, 4'h0);
      `CHK({ds, ds_rsvd, ext_reg[7:1]}, {c[2:0], c == 0 || c == 4, c[2:0], 4'h8})
    end
    d = 8'(xs());
    u_host.send(FERS_OP_SET_EXT_NV, d, 1'b0, 1'b1, 4'h0);
    `CHK({nv_req, nv_data, ext_nv}, {1'b1, d & 8'he0 | 8'h10, d & 8'he0 | 8'h10})
    u_host.send(FERS_OP_SET_EXT_NV, ~d, 1'b0, 1'b0, 4'h0);
    u_host.send(FERS_OP_SET_EXT_V, ~d, 1'b0, 1'b0, 4'h0);
    `CHK({nv_req, ext_reg[7:5], ext_nv[7:5]}, {1'b0, d[7:5], d[7:5]})
    for (int i = 0; i < 32; i++)
    begin
      rn = xs();
      q = (i % 8 < 4) & rn[0];
      dc = (i < 16) ? 4'h0 : rn[7:4];
      u_host.send(rd_ops[i % 8], 8'h00, q, 1'b0, dc);
      `CHK({dum_v, dum_n}, {1'b1, exp_dum(rd_ops[i % 8], q, dc)})
    end
    u_host.send(FERS_OP_DUAL_IO_DTR, 8'h00, 1'b1, 1'b0, 4'h0);
    `CHK({rej, dum_v}, 2'b10)
    for (int k = 0; k < 11; k++)
    begin
      rn = xs();
      fl = mk(k, rn[0], rn[1], r);
      u_host.send(clr_op, 8'h00, 1'b0, 1'b0, 4'h0);
      `CHK(ext_reg[3:1], 3'h0)
      put_result(r);
      `CHK(ext_reg[3:1], fl)
      u_host.send(FERS_OP_SET_EXT_V, rn[15:8], 1'b0, 1'b1, 4'h0);
      `CHK({ext_reg[7:5], ext_reg[3:1]}, {rn[15:13], fl})
    end
    // clear and failure in one cycle: the failure must survive
    for (int k = 0; k < 8; k += 7)
    begin
      fl = mk(k, k == 0, k == 7, r);
      fork
        u_host.send(clr_op, 8'h00, 1'b0, 1'b0, 4'h0);
        put_result(r);
      join
      `CHK(ext_reg[3:1], fl)
    end
    fl = mk(4, 1'b1, 1'b1, r);
    put_result(r);
    `CHK(ext_reg[3:1], fl)
    @(posedge clk_i);
    soft_reset_i <= 1'b1;
    @(posedge clk_i);
    soft_reset_i <= 1'b0;
    #1;
    `CHK(ext_reg[7:1], {d[7:5], 4'h8})
    finish_test();
  end
endmodule
bind fers_regs fers_regs_chk #(.CLR_OPCODE(CLR_OPCODE), .DUMMY_W(DUMMY_W)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .soft_reset_i(soft_reset_i), .cmd_valid_i(cmd_valid_i),
  .cmd_i(cmd_i), .write_enable_latch_i(write_enable_latch_i),
  .write_in_progress_i(write_in_progress_i), .dummy_cfg_i(dummy_cfg_i),
  .result_valid_i(result_valid_i), .result_i(result_i), .ext_reg_o(ext_reg_o),
  .ext_reg_nv_o(ext_reg_nv_o), .nv_write_req_o(nv_write_req_o),
  .nv_write_data_o(nv_write_data_o), .dummy_valid_o(dummy_valid_o),
  .dummy_cycles_o(dummy_cycles_o), .cmd_rejected_o(cmd_rejected_o));
`default_nettype wire
